// ### hdl/cxu_unit.sv
// exception entry and exit unit of the core
// Function
// - entry writes return address into the link register banked for the target mode
// - entry copies current status word into the target mode's saved status word
// - entry forces mode bits then fetches from the exception vector
// - entry may set interrupt disable flags against uncontrolled nesting
// - from 32-bit state link is pc+4, or pc+8 for data abort
// - from 16-bit state link is +2 call/undef/bl, +4 irq/pabt, +8 dabt
// - entry from 16-bit state switches to 32-bit state with the vector load
// - return restores status word including instruction-state bit, no explicit switch
// - low fast_irq_n/normal_irq_n request; sync select low adds synchroniser delay
// - fast mask clear means fast request tested at every instruction end
// - fast mask cannot be set from user mode
// - normal interrupt ranks below fast and is masked on fast entry
// - normal mask set disables normal irq, set only when privileged, cleared from any mode
// - memory may signal abort, sampled during memory access cycles
// - prefetch abort marks instruction invalid, taken only if it executes
// - data abort on single transfer keeps base write-back
// - data abort on swap leaves state as if never executed
// - data abort on block transfer completes, write-back kept, later overwrites suppressed
// - vectors 0x0 reset,4 undef,8 call,c pabt,10 dabt,18 normal,1c fast
// - priority reset, dabt, fast, normal, pabt, then undef or call
// - dabt with enabled fast enters abort then immediately fast vector
// - supervisor call enters supervisor mode; undecodable instruction enters undefined mode
// - mode field encodes fast 10001 normal 10010 svc 10011 abort 10111 und 11011
// - set mask bit in status word disables the corresponding interrupt
`timescale 1ns/1ps
`include "cxu_defines.svh"

module cxu_unit
  import cxu_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // interrupt pins
  input  wire logic        fast_irq_n,
  input  wire logic        normal_irq_n,
  input  wire logic        irq_sync_select,
  // memory abort
  input  wire logic        abort_in,
  input  wire logic        mem_access,
  input  wire logic        mem_is_fetch,
  // pipeline status
  input  wire logic        instr_end,
  input  wire logic        head_executes,
  input  wire logic        head_flushed,
  input  wire logic        fetch_strobe,
  input  wire logic        is_undefined,
  input  wire logic        is_supervisor_call,
  input  wire logic        is_swap,
  input  wire logic        is_block,
  input  wire logic [31:0] pc,
  // status word writes and return
  input  wire logic        status_wr,
  input  wire logic [31:0] status_wr_data,
  input  wire logic        exc_return,
  // entry outputs
  output logic             entry_valid,
  output logic [31:0]      entry_vector,
  output logic [4:0]       entry_mode,
  output logic [31:0]      banked_link_register,
  output logic [31:0]      saved_status_word,
  output logic [31:0]      current_status_word,
  output cxu_exc_type      entry_kind,
  // abort effects
  output cxu_abort_fx_type abort_fx
);

  // synchronisers
  logic [1:0] firq_sync_reg;
  logic [1:0] normal_irq_n_sync_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      firq_sync_reg <= 2'h3;
      normal_irq_n_sync_reg <= 2'h3;
    end else begin
      firq_sync_reg <= {firq_sync_reg[0], fast_irq_n};
      normal_irq_n_sync_reg <= {normal_irq_n_sync_reg[0], normal_irq_n};
    end
  end
  wire firq_lvl_n = irq_sync_select ? fast_irq_n : firq_sync_reg[1];
  wire normal_irq_n_lvl_n = irq_sync_select ? normal_irq_n : normal_irq_n_sync_reg[1];

  // abort capture
  logic pabt_pend_reg;
  logic dabt_pend_reg;
  wire  abort_seen = abort_in && mem_access;
  wire  pabt_take  = pabt_pend_reg && head_executes;
  wire  pabt_mark  = abort_seen && mem_is_fetch;
  wire  dabt_mark  = abort_seen && !mem_is_fetch;

  logic [31:0] status_reg;
  logic [31:0] saved_reg;
  logic [31:0] link_reg;
  logic [31:0] vector_reg;
  logic [4:0]  mode_reg;
  logic        valid_reg;
  cxu_exc_type kind_reg;
  logic        chain_firq_reg;
  cxu_abort_fx_type fx_reg;

  wire privileged = status_reg[4:0] != `CXU_MODE_USER;
  wire tstate     = status_reg[`CXU_BIT_TSTATE];
  wire firq_en    = !status_reg[`CXU_BIT_FIRQ_MASK];
  wire normal_irq_n_en    = !status_reg[`CXU_BIT_NORMAL_IRQ_N_MASK];
  wire firq_req   = !firq_lvl_n && firq_en && instr_end;
  wire normal_irq_n_req   = !normal_irq_n_lvl_n && normal_irq_n_en && instr_end;

  // priority select
  cxu_exc_type sel;
  always_comb begin
    sel = CXU_EXC_NONE;
    if (dabt_pend_reg && instr_end)        sel = CXU_EXC_DABT;
    else if (firq_req || chain_firq_reg)   sel = CXU_EXC_FIRQ;
    else if (normal_irq_n_req)                     sel = CXU_EXC_NORMAL_IRQ_N;
    else if (pabt_take)                    sel = CXU_EXC_PABT;
    else if (instr_end && is_undefined)    sel = CXU_EXC_UNDEF;
    else if (instr_end && is_supervisor_call) sel = CXU_EXC_SVC;
  end

  // per kind mode, vector and link offset
  logic [4:0]  sel_mode;
  logic [31:0] sel_vec;
  logic [31:0] sel_ofs;
  always_comb begin
    sel_mode = status_reg[4:0];
    sel_vec  = `CXU_VEC_RESET;
    sel_ofs  = `CXU_OFS_4;
    case (sel)
      CXU_EXC_DABT: begin
        sel_mode = `CXU_MODE_ABT;
        sel_vec  = `CXU_VEC_DABT;
        sel_ofs  = `CXU_OFS_8;
      end
      CXU_EXC_FIRQ: begin
        sel_mode = `CXU_MODE_FIRQ;
        sel_vec  = `CXU_VEC_FIRQ;
      end
      CXU_EXC_NORMAL_IRQ_N: begin
        sel_mode = `CXU_MODE_NORMAL_IRQ_N;
        sel_vec  = `CXU_VEC_NORMAL_IRQ_N;
      end
      CXU_EXC_PABT: begin
        sel_mode = `CXU_MODE_ABT;
        sel_vec  = `CXU_VEC_PABT;
      end
      CXU_EXC_UNDEF: begin
        sel_mode = `CXU_MODE_UND;
        sel_vec  = `CXU_VEC_UNDEF;
        sel_ofs  = tstate ? `CXU_OFS_2 : `CXU_OFS_4;
      end
      CXU_EXC_SVC: begin
        sel_mode = `CXU_MODE_SVC;
        sel_vec  = `CXU_VEC_SVC;
        sel_ofs  = tstate ? `CXU_OFS_2 : `CXU_OFS_4;
      end
      default: begin
        sel_mode = status_reg[4:0];
        sel_vec  = `CXU_VEC_RESET;
        sel_ofs  = `CXU_OFS_4;
      end
    endcase
  end

  wire take = sel != CXU_EXC_NONE;

  // new status word on entry
  logic [31:0] entry_status;
  always_comb begin
    entry_status = status_reg;
    entry_status[4:0] = sel_mode;
    entry_status[`CXU_BIT_TSTATE] = 1'b0;
    entry_status[`CXU_BIT_NORMAL_IRQ_N_MASK] = 1'b1;
    if (sel == CXU_EXC_FIRQ)
      entry_status[`CXU_BIT_FIRQ_MASK] = 1'b1;
  end

  // software status write with privilege check
  logic [31:0] sw_status;
  always_comb begin
    sw_status = status_wr_data;
    if (!privileged) begin
      sw_status = status_reg;
      sw_status[31:8] = status_wr_data[31:8];
      if (!status_wr_data[`CXU_BIT_FIRQ_MASK])
        sw_status[`CXU_BIT_FIRQ_MASK] = 1'b0;
      if (!status_wr_data[`CXU_BIT_NORMAL_IRQ_N_MASK])
        sw_status[`CXU_BIT_NORMAL_IRQ_N_MASK] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pabt_pend_reg <= 1'b0;
      dabt_pend_reg <= 1'b0;
    end else begin
      pabt_pend_reg <= pabt_mark || (pabt_pend_reg && !head_flushed && !pabt_take &&
                       !fetch_strobe);
      dabt_pend_reg <= dabt_mark || (dabt_pend_reg && sel != CXU_EXC_DABT);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg     <= `CXU_RST_STATUS;
      saved_reg      <= 32'h0;
      link_reg       <= 32'h0;
      vector_reg     <= `CXU_VEC_RESET;
      mode_reg       <= `CXU_MODE_SVC;
      valid_reg      <= 1'b0;
      kind_reg       <= CXU_EXC_NONE;
      chain_firq_reg <= 1'b0;
    end else begin
      valid_reg <= take;
      kind_reg  <= sel;
      chain_firq_reg <= (sel == CXU_EXC_DABT) && !firq_lvl_n && firq_en;
      if (take) begin
        link_reg   <= pc + sel_ofs;
        saved_reg  <= status_reg;
        status_reg <= entry_status;
        vector_reg <= sel_vec;
        mode_reg   <= sel_mode;
      end else if (exc_return) begin
        status_reg <= saved_reg;
      end else if (status_wr) begin
        status_reg <= sw_status;
      end
    end
  end

  // abort effects per instruction type
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fx_reg <= '0;
    end else if (dabt_mark) begin
      fx_reg.undo     <= is_swap;
      fx_reg.keep_wb  <= !is_swap;
      fx_reg.supp_all <= is_block;
    end else if (instr_end) begin
      fx_reg <= '0;
    end
  end

  assign entry_valid          = valid_reg;
  assign entry_vector         = vector_reg;
  assign entry_mode           = mode_reg;
  assign banked_link_register = link_reg;
  assign saved_status_word    = saved_reg;
  assign current_status_word  = status_reg;
  assign entry_kind           = kind_reg;
  assign abort_fx             = fx_reg;

  // checks
  property p_dabt_link;
    @(posedge core_clk) disable iff (!rst_n)
      (sel == CXU_EXC_DABT) |=> link_reg == $past(pc) + `CXU_OFS_8;
  endproperty
  a_dabt_link: assert property (p_dabt_link) else $error("dabt link wrong");

  property p_saved;
    @(posedge core_clk) disable iff (!rst_n)
      take |=> saved_reg == $past(status_reg);
  endproperty
  a_saved: assert property (p_saved) else $error("saved status wrong");

  property p_tclear;
    @(posedge core_clk) disable iff (!rst_n)
      take |=> !status_reg[`CXU_BIT_TSTATE] && entry_valid;
  endproperty
  a_tclear: assert property (p_tclear) else $error("state bit not cleared");

  property p_firq_vec;
    @(posedge core_clk) disable iff (!rst_n)
      (sel == CXU_EXC_FIRQ) |=> entry_vector == `CXU_VEC_FIRQ && entry_mode == `CXU_MODE_FIRQ;
  endproperty
  a_firq_vec: assert property (p_firq_vec) else $error("fast vector wrong");

  property p_normal_irq_n_mask;
    @(posedge core_clk) disable iff (!rst_n)
      (sel == CXU_EXC_FIRQ) |=> status_reg[`CXU_BIT_NORMAL_IRQ_N_MASK];
  endproperty
  a_normal_irq_n_mask: assert property (p_normal_irq_n_mask) else $error("normal not masked");

  property p_user_fmask;
    @(posedge core_clk) disable iff (!rst_n)
      (status_wr && !take && !exc_return && !privileged && !status_reg[`CXU_BIT_FIRQ_MASK])
        |=> !status_reg[`CXU_BIT_FIRQ_MASK];
  endproperty
  a_user_fmask: assert property (p_user_fmask) else $error("user set fast mask");

  property p_return;
    @(posedge core_clk) disable iff (!rst_n)
      (exc_return && !take) |=> status_reg == $past(saved_reg);
  endproperty
  a_return: assert property (p_return) else $error("return restore wrong");

  sequence s_dabt_entry;
    (sel == CXU_EXC_DABT) && !firq_lvl_n && firq_en;
  endsequence
  property p_chain;
    @(posedge core_clk) disable iff (!rst_n)
      s_dabt_entry |=> (sel == CXU_EXC_FIRQ) ##1 entry_vector == `CXU_VEC_FIRQ;
  endproperty
  a_chain: assert property (p_chain) else $error("no fast chain after dabt");

  property p_svc_mode;
    @(posedge core_clk) disable iff (!rst_n)
      (sel == CXU_EXC_SVC) |=> entry_mode == `CXU_MODE_SVC && entry_vector == `CXU_VEC_SVC;
  endproperty
  a_svc_mode: assert property (p_svc_mode) else $error("svc entry wrong");

  property p_swap_undo;
    @(posedge core_clk) disable iff (!rst_n)
      (dabt_mark && is_swap) |=> abort_fx.undo && !abort_fx.keep_wb;
  endproperty
  a_swap_undo: assert property (p_swap_undo) else $error("swap not undone");

endmodule : cxu_unit

// ### shared/cxu_defines.svh
// constants for the exception entry and exit unit
`ifndef CXU_DEFINES_SVH
`define CXU_DEFINES_SVH
`define CXU_VEC_RESET   32'h0000_0000
`define CXU_VEC_UNDEF   32'h0000_0004
`define CXU_VEC_SVC     32'h0000_0008
`define CXU_VEC_PABT    32'h0000_000c
`define CXU_VEC_DABT    32'h0000_0010
`define CXU_VEC_NORMAL_IRQ_N    32'h0000_0018
`define CXU_VEC_FIRQ    32'h0000_001c
`define CXU_MODE_USER   5'h10
`define CXU_MODE_FIRQ   5'h11
`define CXU_MODE_NORMAL_IRQ_N   5'h12
`define CXU_MODE_SVC    5'h13
`define CXU_MODE_ABT    5'h17
`define CXU_MODE_UND    5'h1b
`define CXU_OFS_2       32'h0000_0002
`define CXU_OFS_4       32'h0000_0004
`define CXU_OFS_8       32'h0000_0008
`define CXU_BIT_NORMAL_IRQ_N_MASK 7
`define CXU_BIT_FIRQ_MASK 6
`define CXU_BIT_TSTATE    5
`define CXU_RST_STATUS  32'h0000_00d3
`endif

// ### shared/cxu_pkg.sv
// types for the exception entry and exit unit
package cxu_pkg;
  typedef enum logic [2:0] {
    CXU_EXC_NONE,
    CXU_EXC_RESET,
    CXU_EXC_DABT,
    CXU_EXC_FIRQ,
    CXU_EXC_NORMAL_IRQ_N,
    CXU_EXC_PABT,
    CXU_EXC_UNDEF,
    CXU_EXC_SVC
  } cxu_exc_type;

  typedef struct packed {
    logic        valid;
    logic [4:0]  mode;
    logic [31:0] vector;
    logic [31:0] link;
    logic [31:0] saved;
  } cxu_entry_type;

  typedef struct packed {
    logic supp_all;
    logic keep_wb;
    logic undo;
  } cxu_abort_fx_type;
endpackage : cxu_pkg

// ### dv/cxu_far_model.sv
// interrupt source and abort-signalling memory facing the exception unit
`timescale 1ns/1ps

module cxu_far_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // commands from the bench
  input  wire logic fire_fast,
  input  wire logic fire_normal,
  input  wire logic abort_req,
  input  wire logic mem_access,
  // pins toward the unit
  output logic      fast_irq_n,
  output logic      normal_irq_n,
  output logic      abort_in
);
  logic junk_reg;

  // abort line shows garbage outside access cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) junk_reg <= 1'b0;
    else junk_reg <= ~junk_reg;
  end

  assign fast_irq_n   = ~fire_fast;
  assign normal_irq_n = ~fire_normal;
  assign abort_in     = mem_access ? abort_req : junk_reg;
endmodule : cxu_far_model

// ### dv/tb_top.sv
// self-checking bench for the exception entry and exit unit
`timescale 1ns/1ps

module tb_top
  import cxu_pkg::*;
;
  logic             core_clk, rst_n, irq_sync_select, mem_access, mem_is_fetch, instr_end;
  logic             head_executes, head_flushed, fetch_strobe, is_undefined, is_supervisor_call;
  logic             is_swap, is_block, status_wr, exc_return, fire_fast, fire_normal, abort_req;
  logic             fast_irq_n, normal_irq_n, abort_in, entry_valid;
  logic [31:0]      pc, status_wr_data, entry_vector, banked_link_register;
  logic [31:0]      saved_status_word, current_status_word;
  logic [4:0]       entry_mode;
  cxu_exc_type      entry_kind;
  cxu_abort_fx_type abort_fx;
  int               failures = 0;
  int               samples_checked = 0;
  int               cycles = 0;

  cxu_unit DUT (.core_clk, .rst_n, .fast_irq_n, .normal_irq_n, .irq_sync_select, .abort_in,
    .mem_access, .mem_is_fetch, .instr_end, .head_executes, .head_flushed, .fetch_strobe,
    .is_undefined, .is_supervisor_call, .is_swap, .is_block, .pc, .status_wr, .status_wr_data,
    .exc_return, .entry_valid, .entry_vector, .entry_mode, .banked_link_register,
    .saved_status_word, .current_status_word, .entry_kind, .abort_fx);

  cxu_far_model far (.core_clk, .rst_n, .fire_fast, .fire_normal, .abort_req, .mem_access,
    .fast_irq_n, .normal_irq_n, .abort_in);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic close_out;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge core_clk);
    #10;
  endtask : tick

  task automatic expect_entry(input logic [31:0] v, l, s, c, input logic [4:0] m, input cxu_exc_type k);
    chk({31'h0, entry_valid}, 32'h1);
    chk(entry_vector, v);
    chk({27'h0, entry_mode}, {27'h0, m});
    chk(banked_link_register, l);
    chk(saved_status_word, s);
    chk(current_status_word, c);
    chk({29'h0, entry_kind}, {29'h0, k});
  endtask : expect_entry

  task automatic fire(input logic [3:0] s, input logic [31:0] p);
    {is_supervisor_call, is_undefined, fire_fast, fire_normal} = s;
    pc = p;
    instr_end = 1'b1;
    tick;
    {is_supervisor_call, is_undefined, fire_fast, fire_normal, instr_end} = 5'h00;
  endtask : fire

  task automatic ret(input logic [31:0] st, input string n);
    exc_return = 1'b1;
    tick;
    exc_return = 1'b0;
    chk(current_status_word, st);
    $display("test %s done", n);
  endtask : ret

  task automatic wst(input logic [31:0] d, input logic [31:0] e);
    status_wr = 1'b1;
    status_wr_data = d;
    tick;
    status_wr = 1'b0;
    chk(current_status_word, e);
    tick;
  endtask : wst

  task automatic dabt(input logic [1:0] k, input logic [2:0] fx, input logic [31:0] p);
    {is_swap, is_block} = k;
    pc = p;
    {mem_access, abort_req} = 2'b11;
    tick;
    {mem_access, abort_req} = 2'b00;
    chk({29'h0, abort_fx}, {29'h0, fx});
    instr_end = 1'b1;
    tick;
    {instr_end, is_swap, is_block} = 3'b000;
  endtask : dabt

  task automatic pabt(input logic fl, input logic [31:0] p);
    pc = p;
    {mem_access, mem_is_fetch, abort_req} = 3'b111;
    tick;
    {mem_access, mem_is_fetch, abort_req} = 3'b000;
    head_flushed = fl;
    tick;
    head_flushed = 1'b0;
    {head_executes, instr_end} = 2'b11;
    tick;
    {head_executes, instr_end} = 2'b00;
  endtask : pabt

  initial begin
    {rst_n, irq_sync_select, mem_access, mem_is_fetch, instr_end, head_executes, head_flushed} = 7'h20;
    {fetch_strobe, is_undefined, is_supervisor_call, is_swap, is_block, status_wr} = 6'h00;
    {exc_return, fire_fast, fire_normal, abort_req} = 4'h0;
    pc = 32'h0;
    status_wr_data = 32'h0;
    repeat (16) @(posedge core_clk);
    #10 rst_n = 1'b1;
    chk(current_status_word, 32'hd3);
    chk(entry_vector, 32'h0);
    fire(4'h3, 32'h80);
    chk({31'h0, entry_valid}, 32'h0);
    $display("test masked done");
    wst(32'h10, 32'h10);
    wst(32'hd0, 32'h10);
    $display("test status write done");
    fire(4'h3, 32'h100);
    expect_entry(32'h1c, 32'h104, 32'h10, 32'hd1, 5'h11, CXU_EXC_FIRQ);
    ret(32'h10, "fast");
    fire(4'h5, 32'h140);
    expect_entry(32'h18, 32'h144, 32'h10, 32'h92, 5'h12, CXU_EXC_NORMAL_IRQ_N);
    ret(32'h10, "normal");
    fire(4'h4, 32'h180);
    expect_entry(32'h4, 32'h184, 32'h10, 32'h9b, 5'h1b, CXU_EXC_UNDEF);
    ret(32'h10, "undefined");
    fire(4'h8, 32'h1c0);
    expect_entry(32'h8, 32'h1c4, 32'h10, 32'h93, 5'h13, CXU_EXC_SVC);
    ret(32'h10, "call");
    dabt(2'b00, 3'b010, 32'h200);
    expect_entry(32'h10, 32'h208, 32'h10, 32'h97, 5'h17, CXU_EXC_DABT);
    ret(32'h10, "single abort");
    dabt(2'b10, 3'b001, 32'h240);
    expect_entry(32'h10, 32'h248, 32'h10, 32'h97, 5'h17, CXU_EXC_DABT);
    ret(32'h10, "swap abort");
    dabt(2'b01, 3'b110, 32'h280);
    expect_entry(32'h10, 32'h288, 32'h10, 32'h97, 5'h17, CXU_EXC_DABT);
    ret(32'h10, "block abort");
    pabt(1'b0, 32'h2c0);
    expect_entry(32'hc, 32'h2c4, 32'h10, 32'h97, 5'h17, CXU_EXC_PABT);
    ret(32'h10, "prefetch abort");
    pabt(1'b1, 32'h2e0);
    chk({31'h0, entry_valid}, 32'h0);
    $display("test flushed prefetch done");
    fire_fast = 1'b1;
    dabt(2'b00, 3'b010, 32'h300);
    expect_entry(32'h10, 32'h308, 32'h10, 32'h97, 5'h17, CXU_EXC_DABT);
    tick;
    fire_fast = 1'b0;
    chk(entry_vector, 32'h1c);
    chk(saved_status_word, 32'h97);
    ret(32'h97, "abort then fast");
    wst(32'h30, 32'h30);
    fire(4'h8, 32'h400);
    expect_entry(32'h8, 32'h402, 32'h30, 32'h93, 5'h13, CXU_EXC_SVC);
    ret(32'h30, "short call");
    fire(4'h1, 32'h440);
    expect_entry(32'h18, 32'h444, 32'h30, 32'h92, 5'h12, CXU_EXC_NORMAL_IRQ_N);
    ret(32'h30, "short normal");
    dabt(2'b00, 3'b010, 32'h480);
    expect_entry(32'h10, 32'h488, 32'h30, 32'h97, 5'h17, CXU_EXC_DABT);
    ret(32'h30, "short abort");
    irq_sync_select = 1'b0;
    {fire_normal, instr_end} = 2'b11;
    pc = 32'h500;
    tick;
    chk({31'h0, entry_valid}, 32'h0);
    tick;
    chk({31'h0, entry_valid}, 32'h0);
    tick;
    {fire_normal, instr_end} = 2'b00;
    expect_entry(32'h18, 32'h504, 32'h30, 32'h92, 5'h12, CXU_EXC_NORMAL_IRQ_N);
    ret(32'h30, "synchronised");
    rst_n = 1'b0;
    tick;
    chk(current_status_word, 32'hd3);
    chk({31'h0, entry_valid}, 32'h0);
    rst_n = 1'b1;
    fire(4'h8, 32'h600);
    expect_entry(32'h8, 32'h604, 32'hd3, 32'hd3, 5'h13, CXU_EXC_SVC);
    $display("test second reset done");
    close_out;
  end
endmodule : tb_top
